/* File: dv/alm_ctrl_model.sv */
// Purpose: external controller on the four multifunction pins
// Assumes: push-pull pins, no pull resistor on any line
// Notes:   a pin the device drives reads back its own level
`timescale 1ns/1ns
`default_nettype none
module alm_ctrl_model
  import alm_pkg::*;
(
  // device pins
  input  wire logic [NUM_PINS-1:0] pin_out,
  input  wire logic [NUM_PINS-1:0] pin_oe,
  // controller side
  input  wire logic [NUM_PINS-1:0] ctrl_drive,
  output logic      [NUM_PINS-1:0] pin_in
);
  // wire level: device wins where it drives, else the controller
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ctrl_drive);
endmodule : alm_ctrl_model
`default_nettype wire

/* File: dv/alm_top_monitor.sv */
// Purpose: register bus handshake checks on the alm_top ports
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every alm_top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module alm_top_monitor (
  // clock, reset and register bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before accept");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before accept");
  w_resp_a: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("no write response after address and data");
  r_resp_a: assert property (arvalid && arready |=> rvalid)
    else $error("no read data one cycle after address");
  aw_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write channels ready while response pending");
  ar_busy_a: assert property (rvalid |-> !arready)
    else $error("read address ready while data pending");
  b_done_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated after accept");
  r_done_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated after accept");
  cover property (bvalid && bready && bresp == 2'h2);
  cover property (rvalid && rready && rresp == 2'h2);
  cover property (rvalid && rready && rresp == 2'h0);
endmodule : alm_top_monitor
bind alm_top alm_top_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .rresp(rresp));
`default_nettype wire

/* File: dv/area_output_mapper_test.sv */
// Purpose: self-checking bench of the area output mapper
// Assumes: 16 beams and 10 cycles per ms in the design
// Notes:   registers reached over AXI4-Lite tasks
`timescale 1ns/1ns
`default_nettype none
module area_output_mapper_test
  import alm_pkg::*;
();
  // bus, sensor and pin signals
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, warn_in, trig, teach;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [15:0]       beam_free;
  logic [3:0]        pin_in, pin_out, pin_oe, drive, tv;
  int                n_mismatch = 0, n_compared = 0, k, j;
  // tables: reset words, refused words, {split, beams, areas}, pin steps
  logic [31:0] rst_d [6] = '{32'h0000_0001, 32'h0000_0201, 32'h0000_0301,
                             32'h0000_0301, 32'h0008_0401, 32'h0000_0000};
  logic [31:0] bad_d [5] = '{32'h0000_0501, 32'hfde9_0301, 32'h0000_5301,
                             32'h0000_0009, 32'h0000_0000};
  logic [39:0] spt [7] = '{40'h00_01ff_ff01, 40'h00_02ff_ff03,
    40'h00_02ff_fe02, 40'h01_02ff_fe03, 40'h01_02ff_0002, 40'h01_08ff_f7ff,
    40'h00_08ff_f3fd};
  logic [9:0]  pa [5] = '{10'h144, 10'h144, 10'h148, 10'h150, 10'h150};
  logic [31:0] pd [5] = '{32'h0000_0302, 32'h0000_0303, 32'h0000_0b01,
                          32'h0000_0001, 32'h0000_0000};
  logic [3:0]  pe [5] = '{4'h4, 4'h6, 4'h2, 4'hc, 4'h2};
  logic [3:0]  te [5] = '{4'hc, 4'h4, 4'he, 4'hc, 4'h4};
  // device and the controller on its pins
  alm_top #(.NB(16), .MS_CYC(10)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .beam_free(beam_free),
    .warn_in(warn_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .trigger_act(trig), .teach_act(teach));
  alm_ctrl_model part_u (.pin_out(pin_out), .pin_oe(pin_oe),
    .ctrl_drive(drive), .pin_in(pin_in));
  always #4 aclk = ~aclk;
  // verdict and end of run
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // compare one value, extended to a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one write, response compared
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int i;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      // accept one cycle late, so the response must stand
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (i == 64) n_mismatch++;
    if (i == 64) end_sim();
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  // one read, masked data and response compared
  task automatic rdc(input logic [9:0] a, input logic [31:0] m, e,
                     input logic [1:0] er);
    int i;
    @(posedge aclk);
    {araddr, arvalid} <= {a, 1'b1};
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      // accept one cycle late, so the read data must stand
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (i == 64) n_mismatch++;
    if (i == 64) end_sim();
    chk(rdata & m, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rdc
  // main sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, warn_in, drive} = '0;
    beam_free = 16'hffff;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 6; k++)
      rdc(k ? 10'h13c + 10'(k * 4) : 10'h130, '1, rst_d[k], RESP_OKAY);
    chk({28'h0, pin_oe}, 32'h0000_000e);
    rdc(10'h160, '1, 32'h0, RESP_SLVERR);
    wr(10'h160, 32'h1, RESP_SLVERR);
    for (k = 0; k < 5; k++)
      wr(k < 3 ? 10'h144 : 10'h130, bad_d[k], RESP_SLVERR);
    rdc(10'h144, '1, 32'h0000_0301, RESP_OKAY);
    wr(10'h144, 32'hfde8_0301, RESP_OKAY);
    rdc(10'h144, '1, 32'hfde8_0301, RESP_OKAY);
    // area splitting and area states
    for (k = 0; k < 7; k++) begin
      wr(10'h130, {16'h0, spt[k][39:24]}, RESP_OKAY);
      beam_free <= spt[k][23:8];
      repeat (6) @(posedge aclk);
      rdc(10'h154, 32'hff, {24'h0, spt[k][7:0]}, RESP_OKAY);
    end
    // mask, invert and common driver polarity
    for (k = 0; k < 5; k++) begin
      wr(pa[k], pd[k], RESP_OKAY);
      repeat (8) @(posedge aclk);
      chk({28'h0, pin_out & 4'he}, {28'h0, pe[k]});
    end
    warn_in <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({28'h0, pin_out & 4'he}, 32'h0000_000a);
    // each time mode: early and late samples after rise and fall
    for (k = 0; k < 5; k++) begin
      wr(10'h144, {16'h0003, 1'b0, k[2:0], 12'h302}, RESP_OKAY);
      repeat (8) @(posedge aclk);
      for (j = 0; j < 4; j++) begin
        if (!j[0]) beam_free <= j ? 16'hfff3 : 16'hffff;
        repeat (j[0] ? 39 : 6) @(posedge aclk);
        tv[3-j] = pin_out[1];
      end
      chk({28'h0, tv}, {28'h0, te[k]});
    end
    // a two-cycle pulse is stretched to the time constant, then drops
    wr(10'h144, 32'h0003_3302, RESP_OKAY);
    beam_free <= 16'hffff;
    repeat (2) @(posedge aclk);
    beam_free <= 16'hfff3;
    repeat (12) @(posedge aclk);
    tv[1] = pin_out[1];
    repeat (40) @(posedge aclk);
    tv[0] = pin_out[1];
    chk({30'h0, tv[1:0]}, 32'h0000_0002);
    // teach, trigger and inverted input sense
    drive <= 4'h1;
    repeat (8) @(posedge aclk);
    chk({30'h0, trig, teach}, 32'h0000_0001);
    wr(10'h140, 32'h0000_0101, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk({30'h0, trig, teach}, 32'h0000_0002);
    wr(10'h150, 32'h0000_0001, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk({30'h0, trig, teach}, 32'h0000_0000);
    end_sim();
  end
endmodule : area_output_mapper_test
`default_nettype wire

/* File: verilog/alm_area_eval.sv */
// Purpose: resolves one beam area to a single state bit
// Assumes: beam states come from logic on the same clock
// Notes:   beam numbers count from 1; bit 0 of beam_free is beam 1
`timescale 1ns/1ns
`default_nettype none
module alm_area_eval
  import alm_pkg::*;
#(
  parameter int NB = MAX_BEAMS
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // beams and area setup
  input  wire logic [NB-1:0] beam_free,
  input  wire alm_area_cfg_t cfg,
  // resolved area
  output logic               state_reg
);

  logic all_f;  // every beam of the area free
  logic any_f;  // at least one beam free

  // ----------------------------------------------------------------------
  // combine beams inside the area
  // ----------------------------------------------------------------------
  always_comb begin
    all_f = 1'b1;
    any_f = 1'b0;
    for (int b = 0; b < NB; b++) begin
      if ((b + 1) >= int'(cfg.start) && (b + 1) <= int'(cfg.stop)) begin
        all_f = all_f & beam_free[b];
        any_f = any_f | beam_free[b];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= 1'b0;
    end else begin
      state_reg <= cfg.en & (cfg.any_free ? any_f : all_f);
    end
  end

endmodule : alm_area_eval
`default_nettype wire

/* File: verilog/alm_pkg.sv */
// Purpose: constants, field layouts and carriers of the area output mapper
// Assumes: one 125 MHz clock, synchronous active-low reset
// Notes:   register byte address is four times the register index
//
// Contract
// - one driver polarity for every pin
// - separate settings record per pin
// - polarity zero light, one dark switching
// - function: off, trigger, teach, switch, warning
// - time mode: none, on, off, stretch, suppress
// - time constant in ms, 0 to 65000
// - any area to any output, timed
// - autosplit write rewrites area start, end, condition
// - values 1-8: active while all free
// - values 257-264: active while one free
// - evaluation bit zero AND, one OR
// - area count 1 to 8, default 1
// - each area resolves to one bit
package alm_pkg;

  // ----------------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------------
  localparam int NUM_PINS  = 4;
  localparam int NUM_AREAS = 8;
  localparam int MAX_BEAMS = 1774;       // logical beams of the curtain
  localparam int ADDR_W    = 10;         // byte address width
  localparam int CLK_HZ    = 125_000_000;
  localparam int TICK_MS   = 1;          // time module resolution, ms
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ----------------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_SPLIT = 8'h4c;  // auto_split_control
  localparam logic [7:0] IDX_PIN_A = 8'h50;  // pin_a_settings
  localparam logic [7:0] IDX_PIN_D = 8'h53;  // pin_d_settings
  localparam logic [7:0] IDX_DRV   = 8'h54;  // driver polarity control
  localparam logic [7:0] IDX_STAT  = 8'h55;  // area and pin status

  // ----------------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_OFF    = 3'h0,
    FN_TRIG   = 3'h1,
    FN_TEACH  = 3'h2,
    FN_SWITCH = 3'h3,
    FN_WARN   = 3'h4
  } alm_func_t;

  typedef enum logic [2:0] {
    TM_NONE     = 3'h0,
    TM_ON_DLY   = 3'h1,
    TM_OFF_DLY  = 3'h2,
    TM_STRETCH  = 3'h3,
    TM_SUPPRESS = 3'h4
  } alm_tmode_t;

  localparam logic [2:0]  FN_MAX     = 3'h4;
  localparam logic [2:0]  TM_MAX     = 3'h4;
  localparam logic [15:0] TCONST_MAX = 16'hfde8;  // 65000 ms

  // pin settings word: tconst[31:16] rsvd[15] mode[14:12] inv[11]
  // func[10:8] mask[7:0]
  typedef struct packed {
    logic [15:0] tconst;
    logic        rsvd;
    alm_tmode_t  mode;
    logic        inv;
    alm_func_t   func;
    logic [7:0]  mask;
  } alm_pin_cfg_t;

  localparam logic [7:0]  MASK_RST  = 8'h01;
  localparam logic [15:0] TC_D_RST  = 16'h0008;

  // auto split word: eval[8] count[7:0]
  localparam logic [15:0] SPLIT_RST = 16'h0001;
  localparam int          EVAL_BIT  = 8;
  localparam logic [7:0]  CNT_MIN   = 8'h01;
  localparam logic [7:0]  CNT_MAX   = 8'h08;

  // one area of beams after splitting
  typedef struct packed {
    logic        en;        // area is in use
    logic        any_free;  // 1: one free beam suffices, 0: all free
    logic [15:0] start;     // first beam, counted from 1
    logic [15:0] stop;      // last beam
  } alm_area_cfg_t;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset record of a pin
  function automatic alm_pin_cfg_t pin_rst(input int idx);
    alm_pin_cfg_t c;
    c        = '0;
    c.mask   = MASK_RST;
    c.mode   = TM_NONE;
    c.func   = (idx == 0) ? FN_TEACH :
               (idx == NUM_PINS - 1) ? FN_WARN : FN_SWITCH;
    c.tconst = (idx == NUM_PINS - 1) ? TC_D_RST : 16'h0000;
    return c;
  endfunction : pin_rst

endpackage : alm_pkg

/* File: verilog/alm_time_fn.sv */
// Purpose: time function stage of one output pin
// Assumes: tick is a one-cycle pulse once per millisecond
// Notes:   timing resolves to one tick, so up to one ms of jitter
`timescale 1ns/1ns
`default_nettype none
module alm_time_fn
  import alm_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // timing and settings
  input  wire logic        tick,
  input  wire alm_tmode_t  mode,
  input  wire logic [15:0] tconst,
  // signal path
  input  wire logic        src,
  output logic             out_reg
);

  logic [15:0] cnt_reg;  // elapsed ms

  // ----------------------------------------------------------------------
  // time functions
  // ----------------------------------------------------------------------
  // mode selects function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      case (mode)
        // plain pass-through
        TM_NONE: begin
          out_reg <= src;
          cnt_reg <= '0;
        end
        TM_ON_DLY, TM_SUPPRESS: begin
          if (!src) begin
            out_reg <= 1'b0;
            cnt_reg <= '0;
          end else if (cnt_reg >= tconst) begin
            out_reg <= 1'b1;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        TM_OFF_DLY: begin
          if (src) begin
            out_reg <= 1'b1;
            cnt_reg <= '0;
          end else if (cnt_reg >= tconst) begin
            out_reg <= 1'b0;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        TM_STRETCH: begin
          if (src && !out_reg) begin
            out_reg <= 1'b1;
            cnt_reg <= '0;
          end else if (out_reg) begin
            if (cnt_reg >= tconst) begin
              out_reg <= src;
            end else if (tick) begin
              cnt_reg <= cnt_reg + 16'h0001;
            end
          end
        end
        // out of range mode keeps output off
        default: begin
          out_reg <= 1'b0;
          cnt_reg <= '0;
        end
      endcase
    end
  end

endmodule : alm_time_fn
`default_nettype wire

/* File: verilog/alm_top.sv */
// Purpose: configurable I/O pins of the light curtain with area splitter
// Assumes: AXI4-Lite master, beam and warning states on the same clock
// Notes:   pins are two-way: in, out and output enable per pin
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module alm_top
  import alm_pkg::*;
#(
  parameter int NB     = MAX_BEAMS,  // logical beams
  parameter int MS_CYC = MS_CYCLES   // clock cycles per millisecond
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  // axi4-lite write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // axi4-lite write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  // axi4-lite read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // sensor side
  input  wire logic [NB-1:0]     beam_free,
  input  wire logic              warn_in,
  // multifunction pins
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0]      pin_out,
  output logic [NUM_PINS-1:0]      pin_oe,
  // decoded input functions
  output logic                   trigger_act,
  output logic                   teach_act
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  alm_pin_cfg_t      pin_cfg_reg [NUM_PINS];   // per-pin settings
  logic [15:0]       split_reg;                // auto split word
  logic              drv_npn_reg;              // common driver polarity
  logic              split_go_reg;             // recompute areas
  alm_area_cfg_t     area_cfg_reg [NUM_AREAS]; // split result
  logic [NUM_AREAS-1:0] area_state;            // resolved areas
  logic [NUM_PINS-1:0]  tf_out;                // after time function
  logic [NUM_PINS-1:0]  pin_src;               // before time function
  logic [NUM_PINS-1:0]  pin_lvl;               // logical output level
  logic [NUM_PINS-1:0]  s1_reg, s2_reg, s3_reg; // input synchroniser
  logic [NUM_PINS-1:0]  in_reg;                // filtered input
  logic [NUM_PINS-1:0]  trig_vec, teach_vec;   // active inputs
  logic [31:0]       tick_cnt_reg;             // ms prescaler
  logic              tick_reg;                 // ms pulse
  logic              aw_hold_reg, w_hold_reg;  // captured halves
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              wr_go;                    // both halves present
  logic [7:0]        wr_idx, rd_idx;
  logic [31:0]       wr_old, wr_val;           // merged write word
  alm_pin_cfg_t      wr_pin;
  logic              wr_hit, wr_ok;
  logic [31:0]       rd_val;
  logic              rd_hit;

  // ----------------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 32'(MS_CYC - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  always_comb begin
    wr_go  = aw_hold_reg & w_hold_reg & ~bvalid;
    wr_idx = 8'(aw_addr_reg[ADDR_W-1:2]);
    wr_hit = 1'b1;
    case (wr_idx)
      IDX_SPLIT: wr_old = {16'h0000, split_reg};
      IDX_DRV:   wr_old = {31'h0000_0000, drv_npn_reg};
      default: begin
        if (wr_idx >= IDX_PIN_A && wr_idx <= IDX_PIN_D) begin
          wr_old = pin_cfg_reg[2'(wr_idx - IDX_PIN_A)];
        end else begin
          wr_old = '0;
          wr_hit = 1'b0;
        end
      end
    endcase
    for (int i = 0; i < 4; i++) begin
      wr_val[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8]
                                       : wr_old[i*8 +: 8];
    end
    wr_pin = alm_pin_cfg_t'(wr_val);
    // out of range values refuse the whole write
    if (wr_idx == IDX_SPLIT) begin
      wr_ok = (wr_val[31:9] == '0) && wr_val[7:0] >= CNT_MIN
              && wr_val[7:0] <= CNT_MAX;
    end else if (wr_idx == IDX_DRV) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = (3'(wr_pin.func) <= FN_MAX) && (3'(wr_pin.mode) <= TM_MAX)
              && (wr_pin.tconst <= TCONST_MAX);
    end
    wr_ok = wr_ok & wr_hit;
  end

  // ----------------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
    end else begin
      // address half
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= awaddr;
        awready     <= 1'b0;
      end
      // data half
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        wready     <= 1'b0;
      end
      // response once both halves are in
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      split_reg    <= SPLIT_RST;
      drv_npn_reg  <= 1'b0;
      split_go_reg <= 1'b1;
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_cfg_reg[p] <= pin_rst(p);
      end
    end else begin
      split_go_reg <= 1'b0;
      if (wr_go && wr_ok) begin
        case (wr_idx)
          IDX_SPLIT: begin
            split_reg    <= wr_val[15:0];
            split_go_reg <= 1'b1;
          end
          IDX_DRV: drv_npn_reg <= wr_val[0];
          default: pin_cfg_reg[2'(wr_idx - IDX_PIN_A)] <= wr_pin;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // area splitter
  // ----------------------------------------------------------------------
  // near-equal consecutive areas
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int a = 0; a < NUM_AREAS; a++) begin
        area_cfg_reg[a] <= '0;
      end
    end else if (split_go_reg) begin
      for (int a = 0; a < NUM_AREAS; a++) begin
        area_cfg_reg[a].en    <= a < int'(split_reg[7:0]);
        area_cfg_reg[a].any_free <= split_reg[EVAL_BIT];
        area_cfg_reg[a].start <= 16'(a * NB / int'(split_reg[7:0]) + 1);
        area_cfg_reg[a].stop  <= 16'((a + 1) * NB / int'(split_reg[7:0]));
      end
    end
  end

  // one evaluator per area
  for (genvar a = 0; a < NUM_AREAS; a++) begin : g_area
    alm_area_eval #(.NB(NB)) u_area (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .beam_free (beam_free),
      .cfg       (area_cfg_reg[a]),
      .state_reg (area_state[a])
    );
  end

  // ----------------------------------------------------------------------
  // pin paths
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    assign pin_src[p] =
      (pin_cfg_reg[p].func == FN_SWITCH) ? |(pin_cfg_reg[p].mask & area_state)
      : (pin_cfg_reg[p].func == FN_WARN) ? warn_in : 1'b0;

    alm_time_fn u_tf (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick_reg),
      .mode    (pin_cfg_reg[p].mode),
      .tconst  (pin_cfg_reg[p].tconst),
      .src     (pin_src[p]),
      .out_reg (tf_out[p])
    );

    assign pin_lvl[p]   = tf_out[p] ^ pin_cfg_reg[p].inv;
    assign trig_vec[p]  = (pin_cfg_reg[p].func == FN_TRIG)
                          & (in_reg[p] ^ drv_npn_reg ^ pin_cfg_reg[p].inv);
    assign teach_vec[p] = (pin_cfg_reg[p].func == FN_TEACH)
                          & (in_reg[p] ^ drv_npn_reg ^ pin_cfg_reg[p].inv);
  end

  // input synchroniser and agreement filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      in_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int p = 0; p < NUM_PINS; p++) begin
        if (s2_reg[p] == s3_reg[p]) begin
          in_reg[p] <= s3_reg[p];
        end
      end
    end
  end

  // pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out     <= '0;
      pin_oe      <= '0;
      trigger_act <= 1'b0;
      teach_act   <= 1'b0;
    end else begin
      pin_out     <= pin_lvl ^ {NUM_PINS{drv_npn_reg}};
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_oe[p] <= (pin_cfg_reg[p].func == FN_SWITCH)
                     || (pin_cfg_reg[p].func == FN_WARN);
      end
      trigger_act <= |trig_vec;
      teach_act   <= |teach_vec;
    end
  end

  // ----------------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------------
  always_comb begin
    rd_idx = 8'(araddr[ADDR_W-1:2]);
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_SPLIT: rd_val = {16'h0000, split_reg};
      IDX_DRV:   rd_val = {31'h0000_0000, drv_npn_reg};
      IDX_STAT:  rd_val = {20'h0_0000, pin_lvl, area_state};
      default: begin
        if (rd_idx >= IDX_PIN_A && rd_idx <= IDX_PIN_D) begin
          rd_val = pin_cfg_reg[2'(rd_idx - IDX_PIN_A)];
        end else begin
          rd_val = '0;
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_val;
      rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

endmodule : alm_top
`default_nettype wire
